/* dv/ckg_chk.sv */
// Port checker for the clock status, divider and gating block.
// Assumes it is bound to ckg_top and sees only that module's ports.
`default_nettype none

// ============================================================
// Checker
module ckg_chk
(
    // Clock and reset.
    input wire logic        CLOCK,
    input wire logic        RST,
    // Watched ports.
    input wire logic        RD,
    input wire logic [31:0] RDATA,
    input wire logic        CRYSTAL_STUCK,
    input wire logic        CRYSTAL_MONITOR_ENABLE,
    input wire logic        SLEEP,
    input wire logic        NMI_REQ,
    input wire logic        CRYSTAL_OFF,
    input wire logic        FORCE_FAST_RC,
    input wire logic        PLL_OFF,
    input wire logic [3:0]  PLL_OUTPUT_RATIO,
    input wire logic        CORE_BUS_TICK,
    input wire logic        CONVERTER_TICK,
    input wire logic        UART_CLK_EN,
    input wire logic        RAM_CLK_EN
);
    timeunit 1ns;
    timeprecision 1ps;

    // One clock domain, so one default clock and reset serve all.
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RST);

    // Read data stands only in the cycle after a read strobe.
    AST_RD_IDLE: assert property (!$past(RD) |-> RDATA == 32'h0)
        else $error("read data not zero outside a read answer");
    AST_NMI: assert property (NMI_REQ |-> CRYSTAL_OFF)
        else $error("failure interrupt without stuck flag");
    AST_FAST_RC: assert property (FORCE_FAST_RC == CRYSTAL_OFF)
        else $error("fast RC switch differs from crystal off");
    AST_PLL_OFF: assert property (PLL_OFF |-> CRYSTAL_OFF)
        else $error("PLL off without crystal failure");
    AST_RATIO: assert property ($onehot(PLL_OUTPUT_RATIO))
        else $error("PLL output ratio not a power of two");
    AST_CONV: assert property (CONVERTER_TICK |-> CORE_BUS_TICK)
        else $error("converter tick outside a core tick");
    // A stuck crystal seen for six cycles must raise the flag soon after.
    AST_STUCK: assert property (
        (CRYSTAL_STUCK && CRYSTAL_MONITOR_ENABLE)[*6] |-> ##[0:2] CRYSTAL_OFF)
        else $error("stuck crystal not flagged");
    // The UART gate moves with a core tick, so no runt pulse reaches the UART.
    AST_GATE_EDGE: assert property ($changed(UART_CLK_EN)
        |-> CORE_BUS_TICK)
        else $error("gate changed away from a core tick");

    // Main scenarios.
    COV_NMI: cover property (NMI_REQ);
    COV_CONV: cover property (CONVERTER_TICK);
    COV_SLEEP: cover property (SLEEP && !RAM_CLK_EN);
    COV_GATE: cover property ($rose(UART_CLK_EN));
endmodule // ckg_chk

bind ckg_top ckg_chk i_chk (.*);

`default_nettype wire

/* dv/testbench.sv */
// Self-checking bench for the clock status, divider and gating block.
// Assumes ckg_top alone; the bench drives every pin and models registers.
`default_nettype none

// ============================================================
// Bench top
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // Stimulus, with ready pins matching the reset status pattern.
    logic        CLOCK = 1'b0, RST = 1'b1, WR = 1'b0, RD = 1'b0;
    logic [11:0] ADDR = 12'h0;
    logic [31:0] WDATA = 32'h0;
    logic SLOW_RC_STABLE = 1'b1, FAST_RC_STABLE = 1'b1, CRYSTAL_STABLE = 1'b0;
    logic PLL_STABLE = 1'b0, CRYSTAL_STUCK = 1'b0, SLEEP = 1'b0;
    logic CRYSTAL_MONITOR_ENABLE = 1'b0, PLL_FROM_CRYSTAL = 1'b1;
    // Observed outputs.
    wire logic [31:0] RDATA;
    wire logic [3:0]  PLL_FEEDBACK_DIVIDER, PLL_OUTPUT_RATIO;
    wire logic NMI_REQ, CRYSTAL_OFF, FORCE_FAST_RC, PLL_OFF, PLL_BYPASS;
    wire logic CORE_BUS_TICK, CONVERTER_TICK, BRIDGE_CLK_EN, MATRIX_CLK_EN;
    wire logic RAM_CLK_EN, FLASH_CTRL_CLK_EN, PORT_B_CLK_EN, PORT_A_CLK_EN;
    wire logic REF_CLK_EN, EXT_IRQ_UNIT_CLK_EN, PIN_FUNCTION_CLK_EN;
    wire logic UART_CLK_EN, USART_CLK_EN, SPI_CLK_EN, I2C_CLK_EN;
    wire logic SINGLE_TIMER_1_CLK_EN, SINGLE_TIMER_0_CLK_EN;
    wire logic CONVERTER_CTRL_CLK_EN, BASIC_TIMER_CLK_EN;
    wire logic GENERAL_TIMER_CLK_EN, ALWAYS_ON_ACCESS_CLK_EN;
    wire logic WATCHDOG_ACCESS_CLK_EN;
    // Register model, writable masks and counters.
    logic [31:0] mdl [int];
    logic [31:0] msk [int];
    logic [31:0] seed = 32'h317f;
    logic [11:0] regs [7] = '{12'h018, 12'h01c, 12'h020, 12'h024,
                              12'h028, 12'h02c, 12'h030};
    logic [31:0] msks [7] = '{32'h07e0_0000, 32'h8000_0000, 32'h7,
        32'h0003_0865, 32'h0007_0000, 32'h0000_c511, 32'h3101_0150};
    int err_count = 0, num_checks = 0;

    ckg_top i_dut (.*);

    // Gate outputs gathered at their register bit positions.
    wire logic [31:0] g_core = {14'h0, PORT_B_CLK_EN, PORT_A_CLK_EN, 4'h0,
        REF_CLK_EN, 4'h0, BRIDGE_CLK_EN, MATRIX_CLK_EN, 2'h0, RAM_CLK_EN,
        1'h0, FLASH_CTRL_CLK_EN};
    wire logic [31:0] g_a = {16'h0, EXT_IRQ_UNIT_CLK_EN, PIN_FUNCTION_CLK_EN,
        3'h0, UART_CLK_EN, 1'h0, USART_CLK_EN, 3'h0, SPI_CLK_EN, 3'h0,
        I2C_CLK_EN};
    wire logic [31:0] g_b = {2'h0, SINGLE_TIMER_1_CLK_EN,
        SINGLE_TIMER_0_CLK_EN, 3'h0, CONVERTER_CTRL_CLK_EN, 7'h0,
        BASIC_TIMER_CLK_EN, 7'h0, GENERAL_TIMER_CLK_EN, 1'h0,
        ALWAYS_ON_ACCESS_CLK_EN, 1'h0, WATCHDOG_ACCESS_CLK_EN, 4'h0};

    // 200 MHz system clock.
    always #2.5 CLOCK = ~CLOCK;

    // Pseudo-random source for write data and pin levels.
    function automatic logic [31:0] nxt(input logic [31:0] x);
        nxt = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One-cycle write; the model keeps only writable bits, stuck flag W1C.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge CLOCK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLOCK);
        WR <= 1'b0;
        if (msk.exists(a))
            mdl[a] = (mdl[a] & ~msk[a]) | (d & msk[a]);
        if (a == 12'h00c && d[0])
            mdl[a][0] = 1'b0;
    endtask

    // One-cycle read; data are looked at in the single cycle they stand.
    task automatic rd(input logic [11:0] a);
        @(posedge CLOCK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLOCK);
        RD <= 1'b0;
        #1;
        chk(RDATA, mdl.exists(a) ? mdl[a] : 32'h0);
    endtask

    // Gates and PLL settings against the model, once changes have landed.
    task automatic gates();
        logic [31:0] k;
        logic [31:0] c;
        repeat (40) @(posedge CLOCK);
        #1;
        k = mdl[12'h024];
        c = mdl[12'h018];
        chk(g_core, (k & 32'h0003_0800) | (SLEEP ? k & 32'h65 : 32'h65));
        chk(g_a, mdl[12'h02c]);
        chk(g_b, mdl[12'h030]);
        chk({23'h0, PLL_BYPASS, PLL_FEEDBACK_DIVIDER, PLL_OUTPUT_RATIO},
            {23'h0, mdl[12'h01c][31], c[26:23], 4'h1 << c[22:21]});
    endtask

    // Old periods end within 2100 cycles; 192 is a multiple of every division.
    task automatic count(input int exp_core, input int exp_conv);
        int nc;
        int nv;
        nc = 0;
        nv = 0;
        repeat (2100) @(posedge CLOCK);
        repeat (192)
        begin
            @(posedge CLOCK);
            #1;
            nc += (CORE_BUS_TICK === 1'b1);
            nv += (CONVERTER_TICK === 1'b1);
        end
        chk(nc, exp_core);
        chk(nv, exp_conv);
    endtask

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // A hang counts as a mismatch.
    initial
    begin
        #400us;
        err_count++;
        summarize();
    end

    // Main sequence.
    initial
    begin
        logic mon;
        logic ien;
        mdl[12'h008] = 32'h28;
        msk[12'h008] = 32'h0;
        mdl[12'h00c] = 32'h0;
        msk[12'h00c] = 32'h0001_0000;
        foreach (regs[i])
        begin
            mdl[regs[i]] = 32'h0;
            msk[regs[i]] = msks[i];
        end
        mdl[12'h024] = 32'h65;
        repeat (12) @(posedge CLOCK);
        RST <= 1'b0;
        foreach (mdl[a]) rd(12'(a));
        gates();
        $display("reset values done");
        repeat (4)
        begin
            seed = nxt(seed);
            @(posedge CLOCK);
            {SLOW_RC_STABLE, FAST_RC_STABLE, CRYSTAL_STABLE, PLL_STABLE}
                <= seed[3:0];
            repeat (8) @(posedge CLOCK);
            mdl[12'h008] = {26'h0, seed[3], 1'b0, seed[2:0], 1'b0};
            rd(12'h008);
        end
        $display("ready flags done");
        repeat (3)
        begin
            foreach (regs[j])
            begin
                seed = nxt(seed);
                wr(regs[j], seed);
            end
            wr(12'h020, 32'h0);
            wr(12'h010, seed);
            wr(12'h008, seed);
            SLEEP <= seed[9];
            gates();
            foreach (mdl[a]) rd(12'(a));
            rd(12'h010);
        end
        $display("registers and gates done");
        for (int code = 0; code < 8; code++)
        begin
            wr(12'h020, 32'(code));
            wr(12'h028, 32'h0);
            count(192 >> (code > 5 ? 5 : code), 192 >> (code > 5 ? 5 : code));
            wr(12'h020, 32'h0);
            wr(12'h028, 32'(code) << 16);
            count(192, code == 7 ? 64 : 192 >> code);
        end
        $display("dividers done");
        for (int i = 0; i < 4; i++)
        begin
            mon = i[0];
            ien = i[1];
            @(posedge CLOCK);
            CRYSTAL_MONITOR_ENABLE <= mon;
            PLL_FROM_CRYSTAL <= ~ien;
            wr(12'h00c, {15'h0, ien, 16'h0});
            CRYSTAL_STUCK <= 1'b1;
            repeat (10) @(posedge CLOCK);
            CRYSTAL_STUCK <= 1'b0;
            repeat (8) @(posedge CLOCK);
            mdl[12'h00c][0] = mon;
            rd(12'h00c);
            chk({NMI_REQ, CRYSTAL_OFF, FORCE_FAST_RC, PLL_OFF},
                {ien & mon, mon, mon, mon & ~ien});
            wr(12'h00c, 32'h1);
            rd(12'h00c);
        end
        $display("crystal monitor done");
        summarize();
    end
endmodule // testbench

`default_nettype wire

/* verilog/ckg_regs.vh */
// Register offsets, field positions and reset values of the clock status,
// divider and gating block.
// Assumes a word-addressed byte offset on the register port.
`ifndef CKG_REGS_VH
`define CKG_REGS_VH

// ============================================================
// Register offsets (byte addresses)
`define CKG_ADDR_READY_STATUS   12'h008
`define CKG_ADDR_FAIL_IRQ       12'h00c
`define CKG_ADDR_PLL_DIV_CFG    12'h018
`define CKG_ADDR_PLL_BYPASS     12'h01c
`define CKG_ADDR_CORE_PRESCALE  12'h020
`define CKG_ADDR_CORE_GATES     12'h024
`define CKG_ADDR_CONV_DIVIDER   12'h028
`define CKG_ADDR_PERIPH_GATES_A 12'h02c
`define CKG_ADDR_PERIPH_GATES_B 12'h030

// ============================================================
// Reset values
`define CKG_RST_READY_STATUS    32'h0000_0028
`define CKG_RST_CORE_GATES      32'h0000_0065

// ============================================================
// Field positions
`define CKG_BIT_SLOW_RC_READY   5
`define CKG_BIT_FAST_RC_READY   3
`define CKG_BIT_CRYSTAL_READY   2
`define CKG_BIT_PLL_READY       1
`define CKG_BIT_STUCK_FLAG      0
`define CKG_BIT_STUCK_IRQ_EN    16
`define CKG_FLD_PLL_FB_DIV      26:23
`define CKG_FLD_PLL_OUT_DIV     22:21
`define CKG_BIT_PLL_BYPASS      31
`define CKG_FLD_CORE_DIV        2:0
`define CKG_FLD_CONV_DIV        18:16
`define CKG_BIT_PORT_B          17
`define CKG_BIT_PORT_A          16
`define CKG_BIT_REF_CLK         11
`define CKG_BIT_BRIDGE_KEEP     6
`define CKG_BIT_MATRIX_KEEP     5
`define CKG_BIT_RAM_KEEP        2
`define CKG_BIT_FLASH_KEEP      0
`define CKG_BIT_EXT_IRQ_UNIT    15
`define CKG_BIT_PIN_FUNC        14
`define CKG_BIT_UART            10
`define CKG_BIT_USART           8
`define CKG_BIT_SPI             4
`define CKG_BIT_I2C             0
`define CKG_BIT_SINGLE_TMR1     29
`define CKG_BIT_SINGLE_TMR0     28
`define CKG_BIT_CONV_CTRL       24
`define CKG_BIT_BASIC_TMR       16
`define CKG_BIT_GENERAL_TMR     8
`define CKG_BIT_ALWAYS_ON       6
`define CKG_BIT_WATCHDOG        4

// Writable masks: reserved bits never store.
`define CKG_MASK_PLL_DIV_CFG    32'h07e0_0000
`define CKG_MASK_PLL_BYPASS     32'h8000_0000
`define CKG_MASK_CORE_PRESCALE  32'h0000_0007
`define CKG_MASK_CORE_GATES     32'h0003_0865
`define CKG_MASK_CONV_DIVIDER   32'h0007_0000
`define CKG_MASK_PERIPH_GATES_A 32'h0000_c511
`define CKG_MASK_PERIPH_GATES_B 32'h3101_0150

`endif

/* verilog/ckg_top.v */
// Clock status, divider and gating block of the clock control unit.
// Assumes one system clock CLOCK; oscillator status pins are asynchronous,
// the sleep request and monitor enable come from logic on CLOCK.
// Divided clocks leave as one-cycle enable pulses on CLOCK.
//
// Notes on behaviour
// - Slow RC, fast RC and crystal ready flags at bits 5, 3, 2, read only.
// - PLL ready flag at bit 1 shows PLL output is stable.
// - Stuck flag bit 0 sets on crystal stuck with monitor on; write one clears.
// - Clock failure interrupt raised only while enable bit 16 is one.
// - PLL feedback divider bits 26:23 and output divider bits 22:21 held.
// - Bypass bit 31 passes PLL input straight to its output.
// - Core bus clock divides system clock by 1..16, codes 101-111 by 32.
// - Port B, port A and reference clock gates at bits 17, 16, 11.
// - Bridge, matrix, RAM clocks stop in Sleep unless keep bit is one.
// - Flash controller clock stops in Sleep unless bit 0 is one.
// - Converter clock divides core clock by 1..64, code 111 by 3.
// - Gates for ext irq unit, pin function, UART, USART, SPI, I2C.
// - Gates for two single timers, converter ctrl, basic, general timer.
// - Gates for always-on domain access and watchdog access clocks.
// - Crystal failure turns crystal off, forces fast RC, stops crystal PLL.
// - Clock failure interrupt goes to the non-maskable interrupt input.
//
// Strobed register access was chosen for this implementation.
`include "ckg_regs.vh"
`default_nettype none

module ckg_top
(
    // Clock and reset.
    input  wire        CLOCK,
    input  wire        RST,
    // Register port.
    input  wire [11:0] ADDR,
    input  wire [31:0] WDATA,
    input  wire        WR,
    input  wire        RD,
    output reg  [31:0] RDATA,
    // Oscillator status pins, asynchronous.
    input  wire        SLOW_RC_STABLE,
    input  wire        FAST_RC_STABLE,
    input  wire        CRYSTAL_STABLE,
    input  wire        PLL_STABLE,
    input  wire        CRYSTAL_STUCK,
    // Control from the clock source logic and power controller.
    input  wire        CRYSTAL_MONITOR_ENABLE,
    input  wire        PLL_FROM_CRYSTAL,
    input  wire        SLEEP,
    // Failure handling.
    output reg         NMI_REQ,
    output reg         CRYSTAL_OFF,
    output reg         FORCE_FAST_RC,
    output reg         PLL_OFF,
    // PLL settings.
    output reg  [3:0]  PLL_FEEDBACK_DIVIDER,
    output reg  [3:0]  PLL_OUTPUT_RATIO,
    output reg         PLL_BYPASS,
    // Divided clock enables.
    output reg         CORE_BUS_TICK,
    output reg         CONVERTER_TICK,
    // Bus and memory clock enables.
    output reg         BRIDGE_CLK_EN,
    output reg         MATRIX_CLK_EN,
    output reg         RAM_CLK_EN,
    output reg         FLASH_CTRL_CLK_EN,
    // Peripheral clock enables.
    output reg         PORT_B_CLK_EN,
    output reg         PORT_A_CLK_EN,
    output reg         REF_CLK_EN,
    output reg         EXT_IRQ_UNIT_CLK_EN,
    output reg         PIN_FUNCTION_CLK_EN,
    output reg         UART_CLK_EN,
    output reg         USART_CLK_EN,
    output reg         SPI_CLK_EN,
    output reg         I2C_CLK_EN,
    output reg         SINGLE_TIMER_1_CLK_EN,
    output reg         SINGLE_TIMER_0_CLK_EN,
    output reg         CONVERTER_CTRL_CLK_EN,
    output reg         BASIC_TIMER_CLK_EN,
    output reg         GENERAL_TIMER_CLK_EN,
    output reg         ALWAYS_ON_ACCESS_CLK_EN,
    output reg         WATCHDOG_ACCESS_CLK_EN
);

    // ============================================================
    // Helper functions

    // Core bus division minus one; codes above 100 all give 32.
    function [4:0] core_div_m1;
        input [2:0] code;
        begin
            if (code > 3'h4)
                core_div_m1 = 5'h1f;
            else
                core_div_m1 = (5'h01 << code) - 5'h01;
        end
    endfunction

    // Converter division minus one; code 111 gives 3.
    function [5:0] conv_div_m1;
        input [2:0] code;
        begin
            if (code == 3'h7)
                conv_div_m1 = 6'h02;
            else
                conv_div_m1 = (6'h01 << code) - 6'h01;
        end
    endfunction

    // Three-flop synchroniser with agreement of the last two stages.
    // Stage one feeds only stage two, so metastability stays contained.
    function sync_next;
        input s2;
        input s3;
        input held;
        begin
            sync_next = (s2 == s3) ? s3 : held;
        end
    endfunction

    // ============================================================
    // Register storage

    reg  [3:0]  pll_feedback_divider_r;
    reg  [1:0]  pll_output_divider_r;
    reg         pll_bypass_r;
    reg  [2:0]  core_bus_divider_r;
    reg  [31:0] core_gates_r;
    reg  [2:0]  converter_divider_r;
    reg  [31:0] gates_a_r;
    reg  [31:0] gates_b_r;
    reg         stuck_irq_enable_r;
    reg         stuck_flag_r;
    reg         stuck_flag_nxt;

    wire        wr_stuck = WR && (ADDR == `CKG_ADDR_FAIL_IRQ);

    // Software writes; reserved bits are masked out before storing.
    always @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            pll_feedback_divider_r <= 4'h0;
            pll_output_divider_r   <= 2'h0;
            pll_bypass_r           <= 1'b0;
            core_bus_divider_r     <= 3'h0;
            core_gates_r           <= `CKG_RST_CORE_GATES;
            converter_divider_r    <= 3'h0;
            gates_a_r              <= 32'h0000_0000;
            gates_b_r              <= 32'h0000_0000;
            stuck_irq_enable_r     <= 1'b0;
        end
        else if (WR)
        begin
            case (ADDR)
                `CKG_ADDR_FAIL_IRQ:
                    stuck_irq_enable_r <= WDATA[`CKG_BIT_STUCK_IRQ_EN];
                `CKG_ADDR_PLL_DIV_CFG:
                begin
                    pll_feedback_divider_r <= WDATA[`CKG_FLD_PLL_FB_DIV];
                    pll_output_divider_r   <= WDATA[`CKG_FLD_PLL_OUT_DIV];
                end
                `CKG_ADDR_PLL_BYPASS:
                    pll_bypass_r <= WDATA[`CKG_BIT_PLL_BYPASS];
                `CKG_ADDR_CORE_PRESCALE:
                    core_bus_divider_r <= WDATA[`CKG_FLD_CORE_DIV];
                `CKG_ADDR_CORE_GATES:
                    core_gates_r <= WDATA & `CKG_MASK_CORE_GATES;
                `CKG_ADDR_CONV_DIVIDER:
                    converter_divider_r <= WDATA[`CKG_FLD_CONV_DIV];
                `CKG_ADDR_PERIPH_GATES_A:
                    gates_a_r <= WDATA & `CKG_MASK_PERIPH_GATES_A;
                `CKG_ADDR_PERIPH_GATES_B:
                    gates_b_r <= WDATA & `CKG_MASK_PERIPH_GATES_B;
                default:
                    ;
            endcase
        end
    end

    // ============================================================
    // Oscillator status synchronisers

    // Order: slow RC, fast RC, crystal, PLL, crystal stuck.
    reg  [4:0] sync1_r;
    reg  [4:0] sync2_r;
    reg  [4:0] sync3_r;
    reg  [4:0] status_r;
    wire [4:0] pins = {SLOW_RC_STABLE, FAST_RC_STABLE, CRYSTAL_STABLE,
                       PLL_STABLE, CRYSTAL_STUCK};
    integer    i;

    // RC oscillators start out ready so the status reads its reset value.
    always @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            sync1_r  <= 5'h18;
            sync2_r  <= 5'h18;
            sync3_r  <= 5'h18;
            status_r <= 5'h18;
        end
        else
        begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            for (i = 0; i < 5; i = i + 1)
                status_r[i] <= sync_next(sync2_r[i], sync3_r[i],
                                         status_r[i]);
        end
    end

    wire slow_rc_ready    = status_r[4];
    wire fast_rc_ready    = status_r[3];
    wire crystal_ready    = status_r[2];
    wire pll_locked_ready = status_r[1];
    wire crystal_stuck    = status_r[0];

    // ============================================================
    // Clock stuck flag and failure response

    // A new stuck event beats a write-one clear in the same cycle.
    always @*
    begin
        stuck_flag_nxt = stuck_flag_r;
        if (wr_stuck && WDATA[`CKG_BIT_STUCK_FLAG])
            stuck_flag_nxt = 1'b0;
        if (crystal_stuck && CRYSTAL_MONITOR_ENABLE)
            stuck_flag_nxt = 1'b1;
    end

    // Failure response holds as long as the flag stands, so software
    // must clear the flag before the crystal may be restarted.
    always @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            stuck_flag_r  <= 1'b0;
            NMI_REQ       <= 1'b0;
            CRYSTAL_OFF   <= 1'b0;
            FORCE_FAST_RC <= 1'b0;
            PLL_OFF       <= 1'b0;
        end
        else
        begin
            stuck_flag_r  <= stuck_flag_nxt;
            NMI_REQ       <= stuck_flag_nxt && stuck_irq_enable_r;
            CRYSTAL_OFF   <= stuck_flag_nxt;
            FORCE_FAST_RC <= stuck_flag_nxt;
            PLL_OFF       <= stuck_flag_nxt && PLL_FROM_CRYSTAL;
        end
    end

    // ============================================================
    // PLL settings

    always @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            PLL_FEEDBACK_DIVIDER <= 4'h0;
            PLL_OUTPUT_RATIO     <= 4'h1;
            PLL_BYPASS           <= 1'b0;
        end
        else
        begin
            PLL_FEEDBACK_DIVIDER <= pll_feedback_divider_r;
            PLL_OUTPUT_RATIO     <= 4'h1 << pll_output_divider_r;
            PLL_BYPASS           <= pll_bypass_r;
        end
    end

    // ============================================================
    // Core bus and converter dividers

    reg  [4:0] core_cnt_r;
    reg  [4:0] core_m1_r;
    reg  [5:0] conv_cnt_r;
    reg  [5:0] conv_m1_r;
    wire       core_end = (core_cnt_r == core_m1_r);
    wire       conv_end = core_end && (conv_cnt_r == conv_m1_r);

    // A new code is taken only at the end of a period, so no period is
    // ever cut short; the price is up to one old period of latency.
    always @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            core_cnt_r     <= 5'h00;
            core_m1_r      <= 5'h00;
            conv_cnt_r     <= 6'h00;
            conv_m1_r      <= 6'h00;
            CORE_BUS_TICK  <= 1'b0;
            CONVERTER_TICK <= 1'b0;
        end
        else
        begin
            CORE_BUS_TICK  <= core_end;
            CONVERTER_TICK <= conv_end;
            if (core_end)
            begin
                core_cnt_r <= 5'h00;
                core_m1_r  <= core_div_m1(core_bus_divider_r);
                if (conv_end)
                begin
                    conv_cnt_r <= 6'h00;
                    conv_m1_r  <= conv_div_m1(converter_divider_r);
                end
                else
                    conv_cnt_r <= conv_cnt_r + 6'h01;
            end
            else
                core_cnt_r <= core_cnt_r + 5'h01;
        end
    end

    // ============================================================
    // Clock gates

    // Gates move only on a core bus tick, so a gated clock never gets a
    // runt pulse; Sleep drops the bus clocks whose keep bit is zero.
    always @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            BRIDGE_CLK_EN           <= 1'b1;
            MATRIX_CLK_EN           <= 1'b1;
            RAM_CLK_EN              <= 1'b1;
            FLASH_CTRL_CLK_EN       <= 1'b1;
            PORT_B_CLK_EN           <= 1'b0;
            PORT_A_CLK_EN           <= 1'b0;
            REF_CLK_EN              <= 1'b0;
            EXT_IRQ_UNIT_CLK_EN     <= 1'b0;
            PIN_FUNCTION_CLK_EN     <= 1'b0;
            UART_CLK_EN             <= 1'b0;
            USART_CLK_EN            <= 1'b0;
            SPI_CLK_EN              <= 1'b0;
            I2C_CLK_EN              <= 1'b0;
            SINGLE_TIMER_1_CLK_EN   <= 1'b0;
            SINGLE_TIMER_0_CLK_EN   <= 1'b0;
            CONVERTER_CTRL_CLK_EN   <= 1'b0;
            BASIC_TIMER_CLK_EN      <= 1'b0;
            GENERAL_TIMER_CLK_EN    <= 1'b0;
            ALWAYS_ON_ACCESS_CLK_EN <= 1'b0;
            WATCHDOG_ACCESS_CLK_EN  <= 1'b0;
        end
        else if (core_end)
        begin
            BRIDGE_CLK_EN     <= !SLEEP || core_gates_r[`CKG_BIT_BRIDGE_KEEP];
            MATRIX_CLK_EN     <= !SLEEP || core_gates_r[`CKG_BIT_MATRIX_KEEP];
            RAM_CLK_EN        <= !SLEEP || core_gates_r[`CKG_BIT_RAM_KEEP];
            FLASH_CTRL_CLK_EN <= !SLEEP || core_gates_r[`CKG_BIT_FLASH_KEEP];
            PORT_B_CLK_EN     <= core_gates_r[`CKG_BIT_PORT_B];
            PORT_A_CLK_EN     <= core_gates_r[`CKG_BIT_PORT_A];
            REF_CLK_EN        <= core_gates_r[`CKG_BIT_REF_CLK];
            EXT_IRQ_UNIT_CLK_EN <= gates_a_r[`CKG_BIT_EXT_IRQ_UNIT];
            PIN_FUNCTION_CLK_EN <= gates_a_r[`CKG_BIT_PIN_FUNC];
            UART_CLK_EN         <= gates_a_r[`CKG_BIT_UART];
            USART_CLK_EN        <= gates_a_r[`CKG_BIT_USART];
            SPI_CLK_EN          <= gates_a_r[`CKG_BIT_SPI];
            I2C_CLK_EN          <= gates_a_r[`CKG_BIT_I2C];
            SINGLE_TIMER_1_CLK_EN <= gates_b_r[`CKG_BIT_SINGLE_TMR1];
            SINGLE_TIMER_0_CLK_EN <= gates_b_r[`CKG_BIT_SINGLE_TMR0];
            CONVERTER_CTRL_CLK_EN <= gates_b_r[`CKG_BIT_CONV_CTRL];
            BASIC_TIMER_CLK_EN    <= gates_b_r[`CKG_BIT_BASIC_TMR];
            GENERAL_TIMER_CLK_EN  <= gates_b_r[`CKG_BIT_GENERAL_TMR];
            ALWAYS_ON_ACCESS_CLK_EN <= gates_b_r[`CKG_BIT_ALWAYS_ON];
            WATCHDOG_ACCESS_CLK_EN  <= gates_b_r[`CKG_BIT_WATCHDOG];
        end
    end

    // ============================================================
    // Read path

    reg [31:0] rdata_nxt;

    // Unmapped offsets and reserved bits read as zero.
    always @*
    begin
        rdata_nxt = 32'h0000_0000;
        case (ADDR)
            `CKG_ADDR_READY_STATUS:
            begin
                rdata_nxt[`CKG_BIT_SLOW_RC_READY] = slow_rc_ready;
                rdata_nxt[`CKG_BIT_FAST_RC_READY] = fast_rc_ready;
                rdata_nxt[`CKG_BIT_CRYSTAL_READY] = crystal_ready;
                rdata_nxt[`CKG_BIT_PLL_READY]     = pll_locked_ready;
            end
            `CKG_ADDR_FAIL_IRQ:
            begin
                rdata_nxt[`CKG_BIT_STUCK_IRQ_EN] = stuck_irq_enable_r;
                rdata_nxt[`CKG_BIT_STUCK_FLAG]   = stuck_flag_r;
            end
            `CKG_ADDR_PLL_DIV_CFG:
            begin
                rdata_nxt[`CKG_FLD_PLL_FB_DIV]  = pll_feedback_divider_r;
                rdata_nxt[`CKG_FLD_PLL_OUT_DIV] = pll_output_divider_r;
            end
            `CKG_ADDR_PLL_BYPASS:
                rdata_nxt[`CKG_BIT_PLL_BYPASS] = pll_bypass_r;
            `CKG_ADDR_CORE_PRESCALE:
                rdata_nxt[`CKG_FLD_CORE_DIV] = core_bus_divider_r;
            `CKG_ADDR_CORE_GATES:
                rdata_nxt = core_gates_r;
            `CKG_ADDR_CONV_DIVIDER:
                rdata_nxt[`CKG_FLD_CONV_DIV] = converter_divider_r;
            `CKG_ADDR_PERIPH_GATES_A:
                rdata_nxt = gates_a_r;
            `CKG_ADDR_PERIPH_GATES_B:
                rdata_nxt = gates_b_r;
            default:
                rdata_nxt = 32'h0000_0000;
        endcase
    end

    // Read data stands only in the cycle after the strobe.
    always @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            RDATA <= 32'h0000_0000;
        else if (RD)
            RDATA <= rdata_nxt;
        else
            RDATA <= 32'h0000_0000;
    end

endmodule // ckg_top

`default_nettype wire
